// [apc_predictor.sv]
/*
 * Per-sample ADPCM datapath: pole-zero predictor with reconstruction and
 * coefficient adaptation, tone and transition detection, slow scale factor,
 * and decoder log-PCM output with synchronous coding adjustment.
 * Assumes a sample strobe from logic on clk, at most one every two cycles,
 * with rate and law held stable while samples flow.
 */
module apc_predictor #(
   parameter int TAPS = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clearState,
   input wire logic sampleStrobe,
   input wire apc_pkg::apc_sample_s sampleIn,
   input wire apc_pkg::apc_rate_e rate,
   input wire apc_pkg::apc_law_e law,
   output logic signed [15:0] estimate,
   output logic signed [15:0] zeroSectionEstimate,
   output logic [18:0] slowScale,
   output apc_pkg::apc_result_s result,
   output logic resultValid
);

   // ==========================================================
   // state
   logic signed [15:0] a1Q, a1D;
   logic signed [15:0] a2Q, a2D;
   logic signed [15:0] sr1Q, sr2Q;
   logic pNeg1Q, pNeg2Q;
   logic [18:0] slowQ, slowD;
   logic signed [15:0] estQ;
   logic signed [15:0] zseQ;
   apc_pkg::apc_result_s resultQ, resultD;
   logic validQ;
   logic signed [15:0] dqHistQ [TAPS];
   logic signed [17:0] bQ [TAPS];
   logic signed [33:0] tapProd [TAPS];

   // ==========================================================
   // current sample fields
   logic signed [15:0] dq;
   logic dqZero;
   logic dqNeg;
   logic leak9;
   logic zeroAll;

   assign dq = sampleIn.dq;
   assign dqZero = (dq == 16'sh0000);
   assign dqNeg = dq[15];
   assign leak9 = (rate == apc_pkg::RATE40);

   // ==========================================================
   // zero section taps, history and adaptation
   for (genvar i = 0; i < TAPS; i++) begin : g_tap
      logic signed [17:0] bLeak;
      logic signed [17:0] bStep;
      logic signed [17:0] bNext;
      logic signed [15:0] histIn;

      assign tapProd[i] = bQ[i] * dqHistQ[i];
      assign bLeak = bQ[i] - (leak9 ? (bQ[i] >>> apc_pkg::B_LEAK_SH40) :
                              (bQ[i] >>> apc_pkg::B_LEAK_SH));
      // delayed difference at zero counts as +1, current at zero as 0
      assign bStep = dqZero ? 18'sh0 :
                     ((dqNeg ^ dqHistQ[i][15]) ? -apc_pkg::B_STEP : apc_pkg::B_STEP);
      // wide enough for the implicit bound, so no clamp
      assign bNext = zeroAll ? 18'sh0 : 18'(bLeak + bStep);
      if (i == 0) begin : g_first
         assign histIn = dq;
      end else begin : g_rest
         assign histIn = dqHistQ[i-1];
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            bQ[i] <= 18'sh0;
            dqHistQ[i] <= 16'sh0;
         end else if (clearState) begin
            bQ[i] <= 18'sh0;
            dqHistQ[i] <= 16'sh0;
         end else if (sampleStrobe) begin
            bQ[i] <= bNext;
            dqHistQ[i] <= histIn;
         end
      end
   end

   // ==========================================================
   // signal estimate from stored state
   logic signed [36:0] zeroSum;
   logic signed [22:0] zse;
   logic signed [32:0] poleSum;
   logic signed [22:0] poleEst;
   logic signed [22:0] seWide;
   logic signed [15:0] se;

   always_comb begin
      zeroSum = 37'sh0;
      for (int i = 0; i < TAPS; i++) begin
         zeroSum = zeroSum + 37'(tapProd[i]);
      end
   end

   assign zse = 23'(zeroSum >>> apc_pkg::COEF_FRAC);
   assign poleSum = 33'(a1Q * sr1Q) + 33'(a2Q * sr2Q);
   assign poleEst = 23'(poleSum >>> apc_pkg::COEF_FRAC);
   assign seWide = poleEst + zse;
   assign se = (seWide > 23'sh007fff) ? 16'sh7fff :
               (seWide < -23'sh008000) ? -16'sh8000 : seWide[15:0];

   // ==========================================================
   // reconstruction
   logic signed [16:0] srWide;
   logic signed [15:0] sr;

   assign srWide = 17'(se) + 17'(dq);
   assign sr = (srWide > 17'sh07fff) ? 16'sh7fff :
               (srWide < -17'sh08000) ? -16'sh8000 : srWide[15:0];

   // ==========================================================
   // partial signal signs
   logic signed [22:0] pWide;
   logic pZero;
   logic pNeg;
   logic prodPos;
   logic prodNeg;

   assign pWide = 23'(dq) + zse;
   assign pZero = (pWide == 23'sh0);
   assign pNeg = pWide[22];
   assign prodPos = !pZero && (pNeg == pNeg1Q);
   assign prodNeg = !pZero && (pNeg != pNeg1Q);

   // ==========================================================
   // first pole raw update
   logic signed [16:0] a1Raw;

   assign a1Raw = 17'(a1Q) - 17'(a1Q >>> apc_pkg::A1_LEAK_SH) +
                  (prodPos ? 17'(apc_pkg::A1_STEP) :
                   prodNeg ? -17'(apc_pkg::A1_STEP) : 17'sh0);

   // ==========================================================
   // second pole raw update
   logic a1Small;
   logic signed [18:0] fA1;
   logic signed [18:0] fTerm;
   logic signed [18:0] sgnTwoBack;
   logic signed [19:0] a2Inner;
   logic signed [17:0] a2Raw;

   assign a1Small = (a1Q <= apc_pkg::F_HALF) && (a1Q >= -apc_pkg::F_HALF);
   assign fA1 = a1Small ? 19'(a1Q) <<< 2 :
                (a1Q[15] ? -apc_pkg::F_TWO : apc_pkg::F_TWO);
   assign fTerm = prodPos ? fA1 : prodNeg ? -fA1 : 19'sh0;
   assign sgnTwoBack = pNeg2Q ? -apc_pkg::SGN_ONE : apc_pkg::SGN_ONE;
   assign a2Inner = 20'(sgnTwoBack) - 20'(fTerm);
   assign a2Raw = 18'(a2Q) - 18'(a2Q >>> apc_pkg::A2_LEAK_SH) +
                  18'(a2Inner >>> apc_pkg::A2_LEAK_SH);

   // ==========================================================
   // stability limits
   logic signed [15:0] a2Lim;
   logic signed [16:0] a1Bound;
   logic signed [15:0] a1Lim;

   assign a2Lim = (a2Raw > 18'(apc_pkg::A2_LIMIT)) ? apc_pkg::A2_LIMIT :
                  (a2Raw < -18'(apc_pkg::A2_LIMIT)) ? -apc_pkg::A2_LIMIT :
                  a2Raw[15:0];
   assign a1Bound = apc_pkg::A1_BASE - 17'(a2Lim);
   assign a1Lim = (a1Raw > a1Bound) ? a1Bound[15:0] :
                  (a1Raw < -a1Bound) ? 16'(-a1Bound) : a1Raw[15:0];

   // ==========================================================
   // transition and tone detection
   logic [16:0] dqMag;
   logic [3:0] slowInt;
   logic [5:0] slowMant;
   logic [10:0] thrBase;
   logic [26:0] thrScaled;
   logic [26:0] dqScaled;
   logic trans;
   logic tone;

   assign dqMag = dqNeg ? 17'(17'h0 - 17'(dq)) : 17'(dq);
   assign slowInt = slowQ[18:15];
   assign slowMant = apc_pkg::TRANS_MANT_ONE + 6'(slowQ[14:10]);
   assign thrBase = 11'(apc_pkg::TRANS_MULT) * 11'(slowMant);
   assign thrScaled = 27'(27'(thrBase) << slowInt);
   assign dqScaled = 27'(27'(dqMag) << apc_pkg::TRANS_FRAC_SH);
   assign trans = (a2Q < apc_pkg::TONE_THR) && (dqScaled > thrScaled);
   assign zeroAll = trans;
   assign a1D = zeroAll ? 16'sh0 : a1Lim;
   assign a2D = zeroAll ? 16'sh0 : a2Lim;
   assign tone = (a2D < apc_pkg::TONE_THR);

   // ==========================================================
   // slow scale factor
   logic signed [19:0] slowDiff;

   assign slowDiff = 20'({1'b0, sampleIn.fastScale, 6'h00}) - 20'({1'b0, slowQ});
   assign slowD = 19'(20'({1'b0, slowQ}) + (slowDiff >>> apc_pkg::SLOW_SH));

   // ==========================================================
   // output conversion and check difference
   logic [7:0] pcmRaw;
   logic signed [15:0] sx;
   logic [7:0] pcmAdj;
   logic signed [16:0] dx;
   logic [16:0] dxMag;
   logic stepUp;
   logic stepDown;

   apc_log_pcm u_log_pcm (
      .law(law),
      .recon(sr),
      .stepUp(stepUp),
      .stepDown(stepDown),
      .pcm(pcmRaw),
      .expanded(sx),
      .adjusted(pcmAdj)
   );

   assign dx = 17'(sx) - 17'(se);
   assign dxMag = dx[16] ? 17'(17'h0 - dx) : dx;

   // ==========================================================
   // log of check difference, normalised by scale
   logic [4:0] dxMsb;
   logic [16:0] dxNorm;
   logic [11:0] dxLog;
   logic signed [12:0] dln;

   always_comb begin
      dxMsb = 5'h0;
      for (int i = 0; i < 17; i++) begin
         if (dxMag[i]) dxMsb = 5'(i);
      end
   end

   assign dxNorm = 17'(dxMag << (5'd16 - dxMsb));
   assign dxLog = {dxMsb, dxNorm[15:9]};
   assign dln = 13'({1'b0, dxLog}) - 13'(sampleIn.scale >> 2);

   // ==========================================================
   // requantise check difference against the rate's decision levels
   apc_pkg::apc_thr_t thr;
   logic [apc_pkg::NTHR-1:0] above;
   logic [3:0] reqMag;

   assign thr = (rate == apc_pkg::RATE40) ? apc_pkg::THR40 :
                (rate == apc_pkg::RATE32) ? apc_pkg::THR32 :
                (rate == apc_pkg::RATE24) ? apc_pkg::THR24 : apc_pkg::THR16;

   for (genvar j = 0; j < apc_pkg::NTHR; j++) begin : g_level
      assign above[j] = (dxMag != 17'h0) && (dln >= $signed(thr[j]));
   end

   always_comb begin
      reqMag = 4'h0;
      for (int j = 0; j < apc_pkg::NTHR; j++) begin
         reqMag = reqMag + 4'(above[j]);
      end
   end

   // ==========================================================
   // received code split into sign and magnitude
   logic [4:0] magMask;
   logic rxSign;
   logic [4:0] rxMagFull;
   logic [3:0] rxMag;
   logic signed [5:0] ordRx;
   logic signed [5:0] ordRe;

   assign magMask = (rate == apc_pkg::RATE40) ? 5'h0f :
                    (rate == apc_pkg::RATE32) ? 5'h07 :
                    (rate == apc_pkg::RATE24) ? 5'h03 : 5'h01;
   assign rxSign = |(sampleIn.code & (magMask + 5'h01));
   assign rxMagFull = rxSign ? (~sampleIn.code & magMask) : (sampleIn.code & magMask);
   assign rxMag = (rxMagFull > 5'(apc_pkg::MAGCAP40)) ? apc_pkg::MAGCAP40 : rxMagFull[3:0];
   assign ordRx = rxSign ? (-6'sd1 - 6'(rxMag)) : 6'(rxMag);
   assign ordRe = dx[16] ? (-6'sd1 - 6'(reqMag)) : 6'(reqMag);
   assign stepUp = (ordRe < ordRx);
   assign stepDown = (ordRe > ordRx);

   // ==========================================================
   // result word, decoder shares the encoder datapath
   assign resultD.recon = sr;
   assign resultD.pcm = pcmAdj;
   assign resultD.tone = tone;
   assign resultD.trans = trans;

   // ==========================================================
   // coefficient and history registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         a1Q <= 16'sh0;
         a2Q <= 16'sh0;
         sr1Q <= 16'sh0;
         sr2Q <= 16'sh0;
         pNeg1Q <= 1'b0;
         pNeg2Q <= 1'b0;
         slowQ <= 19'h0;
      end else if (clearState) begin
         a1Q <= 16'sh0;
         a2Q <= 16'sh0;
         sr1Q <= 16'sh0;
         sr2Q <= 16'sh0;
         pNeg1Q <= 1'b0;
         pNeg2Q <= 1'b0;
         slowQ <= 19'h0;
      end else if (sampleStrobe) begin
         a1Q <= a1D;
         a2Q <= a2D;
         sr1Q <= sr;
         sr2Q <= sr1Q;
         pNeg1Q <= pNeg;
         pNeg2Q <= pNeg1Q;
         slowQ <= slowD;
      end
   end

   // ==========================================================
   // output registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         estQ <= 16'sh0;
         zseQ <= 16'sh0;
         resultQ <= '0;
         validQ <= 1'b0;
      end else begin
         estQ <= se;
         zseQ <= 16'(zse);
         validQ <= sampleStrobe && !clearState;
         if (clearState) begin
            resultQ <= '0;
         end else if (sampleStrobe) begin
            resultQ <= resultD;
         end
      end
   end

   assign estimate = estQ;
   assign zeroSectionEstimate = zseQ;
   assign slowScale = slowQ;
   assign result = resultQ;
   assign resultValid = validQ;

endmodule // apc_predictor

// [apc_pkg.sv]
/*
 * Shared types and constants of the ADPCM predictor, tone detector and
 * log-PCM output adjustment datapath.
 * Assumes one 100 MHz clock and samples arriving at the 8 kHz frame rate.
 */
package apc_pkg;

   // ==========================================================
   // modes
   typedef enum logic [1:0] {RATE40, RATE32, RATE24, RATE16} apc_rate_e;
   typedef enum logic {LAW_MU, LAW_A} apc_law_e;

   // ==========================================================
   // fixed point: coefficients in Q14
   localparam int COEF_FRAC = 14;
   localparam int A1_LEAK_SH = 8;
   localparam int A2_LEAK_SH = 7;
   localparam int B_LEAK_SH = 8;
   localparam int B_LEAK_SH40 = 9;
   localparam int SLOW_SH = 6;
   localparam logic signed [15:0] A1_STEP = 16'sh00c0;
   localparam logic signed [17:0] B_STEP = 18'sh00080;
   localparam logic signed [15:0] A2_LIMIT = 16'sh3000;
   localparam logic signed [16:0] A1_BASE = 17'sh03c00;
   localparam logic signed [15:0] TONE_THR = 16'shd200;
   localparam logic signed [15:0] F_HALF = 16'sh2000;
   localparam logic signed [18:0] SGN_ONE = 19'sh04000;
   localparam logic signed [18:0] F_TWO = 19'sh08000;
   localparam logic [4:0] TRANS_MULT = 5'h18;
   localparam logic [5:0] TRANS_MANT_ONE = 6'h20;
   localparam int TRANS_FRAC_SH = 5;

   // ==========================================================
   // quantizer decision levels, log2 domain in Q7, lowest first
   localparam int NTHR = 9;
   typedef logic [NTHR-1:0][12:0] apc_thr_t;
   localparam apc_thr_t THR40 = {13'h017a, 13'h0152, 13'h0129, 13'h00fa, 13'h00c5,
                                 13'h008a, 13'h0043, 13'h1fef, 13'h1f85};
   localparam apc_thr_t THR32 = {13'h0fff, 13'h0fff, 13'h018f, 13'h015c, 13'h012c,
                                 13'h00f4, 13'h00b1, 13'h004f, 13'h1f83};
   localparam apc_thr_t THR24 = {13'h0fff, 13'h0fff, 13'h0fff, 13'h0fff, 13'h0fff,
                                 13'h0fff, 13'h014a, 13'h00da, 13'h1ff8};
   localparam apc_thr_t THR16 = {13'h0fff, 13'h0fff, 13'h0fff, 13'h0fff, 13'h0fff,
                                 13'h0fff, 13'h0fff, 13'h0fff, 13'h0105};
   localparam logic [3:0] MAGCAP40 = 4'h9;

   // ==========================================================
   // companding
   localparam logic [16:0] MU_BIAS = 17'h00021;
   localparam logic [16:0] MU_CLIP = 17'h01fff;
   localparam logic [15:0] A_CLIP = 16'h0fff;
   localparam logic [7:0] MU_MASK = 8'h7f;
   localparam logic [7:0] A_MASK = 8'h55;
   localparam logic [6:0] LVL_TOP = 7'h7f;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic signed [15:0] dq;
      logic [4:0] code;
      logic [12:0] scale;
      logic [12:0] fastScale;
   } apc_sample_s;

   typedef struct packed {
      logic signed [15:0] recon;
      logic [7:0] pcm;
      logic tone;
      logic trans;
   } apc_result_s;

endpackage

// [apc_log_pcm.sv]
/*
 * Log-PCM codec: compands a uniform sample to A-law or mu-law, expands the
 * codeword back, and steps the codeword one level up or down on request.
 * Purely combinational; the instantiating module registers the results.
 */
module apc_log_pcm (
   input wire apc_pkg::apc_law_e law,
   input wire logic signed [15:0] recon,
   input wire logic stepUp,
   input wire logic stepDown,
   output logic [7:0] pcm,
   output logic signed [15:0] expanded,
   output logic [7:0] adjusted
);

   // ==========================================================
   // compression
   logic isA;
   logic neg;
   logic [16:0] absMag;
   logic [16:0] muSum;
   logic [12:0] muVal;
   logic [15:0] aShift;
   logic [11:0] aVal;
   logic [3:0] muMsb;
   logic [3:0] aMsb;
   logic [2:0] seg;
   logic [3:0] mant;
   logic [7:0] mask;

   assign isA = (law == apc_pkg::LAW_A);
   assign mask = isA ? apc_pkg::A_MASK : apc_pkg::MU_MASK;
   assign neg = recon[15];
   assign absMag = neg ? 17'(17'h0 - {recon[15], recon}) : {1'b0, recon};
   assign muSum = absMag + apc_pkg::MU_BIAS;
   assign muVal = (muSum > apc_pkg::MU_CLIP) ? 13'h1fff : muSum[12:0];
   // negative words round by one before halving
   assign aShift = neg ? 16'((absMag - 17'h1) >> 1) : 16'(absMag >> 1);
   assign aVal = (aShift > apc_pkg::A_CLIP) ? 12'hfff : aShift[11:0];

   always_comb begin
      muMsb = 4'h0;
      aMsb = 4'h0;
      for (int i = 0; i < 13; i++) begin
         if (muVal[i]) muMsb = 4'(i);
      end
      for (int i = 0; i < 12; i++) begin
         if (aVal[i]) aMsb = 4'(i);
      end
   end

   always_comb begin
      if (!isA) begin
         seg = 3'(muMsb - 4'h5);
         mant = 4'(muVal >> (muMsb - 4'h4));
      end else if (aVal < 12'h020) begin
         seg = 3'h0;
         mant = aVal[4:1];
      end else begin
         seg = 3'(aMsb - 4'h4);
         mant = 4'(aVal >> 3'(aMsb - 4'h4));
      end
   end

   assign pcm = {~neg, seg, mant} ^ mask;

   // ==========================================================
   // expansion
   logic [7:0] plain;
   logic [15:0] baseLvl;
   logic [15:0] muExp;
   logic [15:0] aExp;
   logic [15:0] expMag;

   assign plain = pcm ^ mask;
   assign baseLvl = 16'({plain[3:0], 1'b0}) + 16'h0021;
   assign muExp = 16'(baseLvl << plain[6:4]) - 16'h0021;
   assign aExp = (plain[6:4] == 3'h0) ? 16'({plain[3:0], 2'b10}) :
                 16'(baseLvl << plain[6:4]);
   assign expMag = isA ? aExp : muExp;
   assign expanded = plain[7] ? expMag : 16'(16'h0 - expMag);

   // ==========================================================
   // one-level step, saturating at both ends
   logic newPos;
   logic [6:0] newLvl;

   always_comb begin
      newPos = plain[7];
      newLvl = plain[6:0];
      if (stepUp) begin
         if (plain[7]) begin
            if (plain[6:0] != apc_pkg::LVL_TOP) newLvl = plain[6:0] + 7'h1;
         end else if (plain[6:0] == 7'h0) begin
            newPos = 1'b1;
         end else begin
            newLvl = plain[6:0] - 7'h1;
         end
      end else if (stepDown) begin
         if (!plain[7]) begin
            if (plain[6:0] != apc_pkg::LVL_TOP) newLvl = plain[6:0] + 7'h1;
         end else if (plain[6:0] == 7'h0) begin
            newPos = 1'b0;
         end else begin
            newLvl = plain[6:0] - 7'h1;
         end
      end
   end

   assign adjusted = {newPos, newLvl} ^ mask;

endmodule // apc_log_pcm

// [apc_predictor_monitor.sv]
/* Concurrent checks on the ports of apc_predictor.
   Assumes one clock domain and binding from the testbench top file. */
module apc_predictor_monitor #(
   parameter int TAPS = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clearState,
   input wire logic sampleStrobe,
   input wire apc_pkg::apc_sample_s sampleIn,
   input wire apc_pkg::apc_rate_e rate,
   input wire apc_pkg::apc_law_e law,
   input wire logic signed [15:0] estimate,
   input wire logic signed [15:0] zeroSectionEstimate,
   input wire logic [18:0] slowScale,
   input wire apc_pkg::apc_result_s result,
   input wire logic resultValid
);
   timeunit 1ns;
   timeprecision 100ps;
   // =========
   // helpers
   logic signed [19:0] slowDelta;
   logic [18:0] slowNext;
   assign slowDelta = $signed({1'b0, sampleIn.fastScale, 6'h00}) - $signed({1'b0, slowScale});
   assign slowNext = slowScale + 19'(slowDelta >>> 6);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence accepted;
      sampleStrobe && !clearState;
   endsequence
   sequence answered;
      resultValid ##1 !resultValid;
   endsequence
   // =========
   // checks
   a_valid_after_strobe: assert property (accepted |=> answered)
      else $error("no single result pulse after sample");
   a_valid_has_cause: assert property (resultValid |-> $past(sampleStrobe && !clearState))
      else $error("result pulse without accepted sample");
   a_clear_zeroes: assert property (clearState |=> result == '0 && slowScale == '0 && !resultValid)
      else $error("clear left state behind");
   a_clear_estimate: assert property (clearState |=> ##1 estimate == '0 && zeroSectionEstimate == '0)
      else $error("estimate not zero after clear");
   a_result_holds: assert property (!sampleStrobe && !clearState |=> $stable(result))
      else $error("result moved without sample");
   a_slow_step: assert property (accepted |=> slowScale == $past(slowNext))
      else $error("slow scale update wrong");
   a_slow_idle: assert property (!sampleStrobe && !clearState |=> $stable(slowScale))
      else $error("slow scale moved without sample");
   a_trans_no_tone: assert property (result.trans |-> !result.tone)
      else $error("tone set during transition");
   a_estimate_lag: assert property (!$stable(estimate) |-> $past(sampleStrobe || clearState, 2))
      else $error("estimate moved without cause");
endmodule // apc_predictor_monitor

// [apc_stream_partner.sv]
/* Sample source and log-PCM sink facing apc_predictor.
   Assumes the caller keeps samples at least two cycles apart. */
module apc_stream_partner (
   input wire logic clk,
   input wire logic resultValid,
   input wire apc_pkg::apc_result_s result,
   output logic sampleStrobe,
   output apc_pkg::apc_sample_s sampleIn,
   output apc_pkg::apc_result_s got,
   output int gotCount
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sampleStrobe = 1'b0;
      sampleIn = '0;
   end
   // =========
   // one-cycle sample strobe
   task automatic sendSample(input apc_pkg::apc_sample_s word);
      @(posedge clk);
      #1;
      sampleStrobe = 1'b1;
      sampleIn = word;
      @(posedge clk);
      #1;
      sampleStrobe = 1'b0;
      sampleIn = ~word; // released word must not linger
   endtask
   always @(posedge clk) begin
      if (resultValid) begin
         got <= result;
         gotCount <= gotCount + 1;
      end
   end
endmodule // apc_stream_partner

// [apc_predictor_tb_top.sv]
/* Testbench of apc_predictor: table of first samples, then a pair, tone, adjust, refusal, reset.
   Assumes apc_pkg, partner model and monitor are compiled before. */
module apc_predictor_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {
      logic signed [15:0] dq;
      logic [12:0] fs;
      logic signed [15:0] rec;
      logic signed [15:0] est;
      logic signed [15:0] zse;
      logic pos;
   } apc_row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clearState = 1'b0;
   apc_pkg::apc_rate_e rate = apc_pkg::RATE32;
   apc_pkg::apc_law_e law = apc_pkg::LAW_MU;
   logic sampleStrobe;
   apc_pkg::apc_sample_s sampleIn;
   logic signed [15:0] estimate;
   logic signed [15:0] zseOut;
   logic [18:0] slowScale;
   apc_pkg::apc_result_s result;
   apc_pkg::apc_result_s got;
   logic resultValid;
   int gotCount;
   int num_errors = 0;
   int n_tests = 0;
   apc_row_s rows [5] = '{
      '{16'sh1000, 13'h0100, 16'sh1000, 16'sh0050, 16'sh0020, 1'b1},
      '{16'shf000, 13'h0a00, 16'shf000, 16'sh0050, 16'sh0020, 1'b0},
      '{16'sh03e8, 13'h1fff, 16'sh03e8, 16'sh0012, 16'sh0007, 1'b1},
      '{16'shfc18, 13'h0001, 16'shfc18, 16'sh0012, 16'sh0007, 1'b0},
      '{16'sh0000, 13'h0842, 16'sh0000, 16'sh0000, 16'sh0000, 1'b0}};
   always #5 clk = ~clk;
   apc_predictor apc_predictor_i (.clk(clk), .rst(rst), .clearState(clearState),
      .sampleStrobe(sampleStrobe), .sampleIn(sampleIn), .rate(rate), .law(law),
      .estimate(estimate), .zeroSectionEstimate(zseOut), .slowScale(slowScale),
      .result(result), .resultValid(resultValid));
   apc_stream_partner apc_stream_partner_i (.clk(clk), .resultValid(resultValid),
      .result(result), .sampleStrobe(sampleStrobe), .sampleIn(sampleIn), .got(got),
      .gotCount(gotCount));
   // =========
   // tasks
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic clearAll(input int idx);
      @(posedge clk);
      #1;
      clearState = 1'b1;
      rate = apc_pkg::apc_rate_e'(2'(idx));
      law = apc_pkg::apc_law_e'(1'(idx));
      @(posedge clk);
      #1;
      clearState = 1'b0;
   endtask
   task automatic sendWait(input logic signed [15:0] dq, input logic [12:0] fs,
         input logic [4:0] code, input logic [12:0] sc);
      int c0;
      c0 = gotCount;
      apc_stream_partner_i.sendSample('{dq, code, sc, fs});
      for (int i = 0; i < 20 && gotCount == c0; i++) @(posedge clk);
      if (gotCount == c0) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, c0, c0 + 1);
         print_verdict();
      end
      @(posedge clk);
      #1;
   endtask
   // =========
   // sequence
   initial begin
      int c0;
      repeat (4) @(posedge clk);
      #1;
      chk({resultValid, slowScale, estimate}, '0);
      chk(result, '0);
      rst = 1'b0;
      $display("test reset done");
      foreach (rows[i]) begin
         clearAll(i);
         sendWait(rows[i].dq, rows[i].fs, 5'h00, 13'h0000);
         chk(got.recon, rows[i].rec);
         chk(slowScale, 19'(rows[i].fs));
         chk({got.tone, got.trans}, 2'b00);
         chk(estimate, rows[i].est);
         chk(zseOut, rows[i].zse);
         if (rows[i].dq != 0) chk(got.pcm[7], rows[i].pos);
      end
      $display("test table done");
      clearAll(0);
      sendWait(16'sh1000, 13'h0100, 5'h00, 13'h0000);
      sendWait(16'sh0000, 13'h0100, 5'h00, 13'h0000);
      chk(got.recon, 16'sh0050);
      chk(estimate, 16'sh0060);
      chk(zseOut, 16'sh0020);
      chk(slowScale, 19'h001fc);
      $display("test pair done");
      clearAll(1);
      for (int k = 0; k < 200 && got.tone !== 1'b1; k++) begin
         sendWait(16'shfc18, 13'h0000, 5'h00, 13'h0000);
      end
      chk(got.tone, 1'b1);
      sendWait(16'shfc18, 13'h0000, 5'h00, 13'h0000);
      chk({got.trans, got.tone}, 2'h2);
      chk({estimate, zseOut}, 32'h0);
      $display("test tone done");
      clearAll(0);
      sendWait(16'sh7fff, 13'h0000, 5'h00, 13'h0000);
      chk(got.pcm, 8'h81);
      clearAll(0);
      sendWait(16'sh7fff, 13'h0000, 5'h0f, 13'h1fff);
      chk(got.pcm, 8'h80);
      $display("test adjust done");
      c0 = gotCount;
      fork
         apc_stream_partner_i.sendSample('{16'sh1000, 5'h00, 13'h0000, 13'h0100});
         clearAll(1);
      join
      repeat (3) @(posedge clk);
      #1;
      chk(gotCount, c0);
      chk({result, estimate}, '0);
      $display("test refusal done");
      sendWait(16'sh1000, 13'h0100, 5'h00, 13'h0000);
      @(posedge clk);
      #1;
      rst = 1'b1;
      #1;
      chk({resultValid, slowScale, estimate}, '0);
      chk(result, '0);
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      sendWait(16'sh1000, 13'h0100, 5'h00, 13'h0000);
      chk(estimate, 16'sh0050);
      $display("test midrun reset done");
      print_verdict();
   end
endmodule // apc_predictor_tb_top

bind apc_predictor apc_predictor_monitor #(.TAPS(TAPS)) apc_predictor_monitor_i (.clk(clk),
   .rst(rst), .clearState(clearState), .sampleStrobe(sampleStrobe), .sampleIn(sampleIn),
   .rate(rate), .law(law), .estimate(estimate), .zeroSectionEstimate(zeroSectionEstimate),
   .slowScale(slowScale), .result(result), .resultValid(resultValid));
